// ==== hw/refclk_div_pkg.sv ====
// package: register map, reset values and types of the reference clock divider block
package refclk_div_pkg;

  // divider geometry
  localparam int DIV_W = 10;
  localparam int DIV_N = 6;

  typedef logic [DIV_W-1:0]            div_val_t;
  typedef logic [DIV_N-1:0][DIV_W-1:0] div_array_t;

  // divider slots inside a divider set
  localparam logic [2:0] DIV_GP_TIMER   = 3'h0;
  localparam logic [2:0] DIV_IDLE_VCO   = 3'h1;
  localparam logic [2:0] DIV_REF        = 3'h2;
  localparam logic [2:0] DIV_PLL        = 3'h3;
  localparam logic [2:0] DIV_ACTIVE_VCO = 3'h4;
  localparam logic [2:0] DIV_CONVERTER  = 3'h5;
  localparam int         DIV_CORE_LO    = 2;

  // values after reset, correct for a 6.144 MHz reference
  localparam div_val_t RST_GP_TIMER   = 10'h018;
  localparam div_val_t RST_IDLE_VCO   = 10'h088;
  localparam div_val_t RST_REF        = 10'h040;
  localparam div_val_t RST_PLL        = 10'h200;
  localparam div_val_t RST_ACTIVE_VCO = 10'h140;
  localparam div_val_t RST_CONVERTER  = 10'h008;
  localparam div_array_t DIV_RESET = {RST_CONVERTER, RST_ACTIVE_VCO, RST_PLL,
                                      RST_REF, RST_IDLE_VCO, RST_GP_TIMER};

  // byte addresses on the register bus
  localparam int         ADDR_W                  = 8;
  localparam logic [7:0] ADDR_GP_TIMER           = 8'h00;
  localparam logic [7:0] ADDR_IDLE_VCO           = 8'h04;
  localparam logic [7:0] ADDR_REF                = 8'h08;
  localparam logic [7:0] ADDR_PLL                = 8'h0C;
  localparam logic [7:0] ADDR_ACTIVE_VCO         = 8'h10;
  localparam logic [7:0] ADDR_CONVERTER          = 8'h14;
  localparam logic [7:0] ADDR_MODE               = 8'h18;
  localparam logic [7:0] ADDR_STATUS             = 8'h1C;

  // status register fields
  localparam int STAT_MODE_LSB  = 0;
  localparam int STAT_PEND_BIT  = 2;

  // operating mode
  typedef enum logic [1:0] {MODE_IDLE, MODE_RX, MODE_TX} op_mode_t;

  // whole state of the configuration block
  typedef struct packed {
    div_array_t  staged;
    div_array_t  applied;
    op_mode_t    mode;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } cfg_state_t;

endpackage : refclk_div_pkg

// ==== hw/refclk_div_cfg.sv ====
// module: divider configuration registers with apb slave and staged application
`timescale 1ns/1ps

module refclk_div_cfg
(
  // clock and reset
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  // apb slave
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [refclk_div_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                      pwdata,
  output logic      [31:0]                      prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  // divider settings in force and operating mode
  output refclk_div_pkg::div_array_t            div_applied,
  output refclk_div_pkg::op_mode_t              op_mode
);
  import refclk_div_pkg::*;

  cfg_state_t st_r;
  cfg_state_t st_nxt;
  logic       setup_acc;
  logic       write_acc;
  logic       core_pending;
  logic [2:0] div_idx;
  logic       div_hit;

  assign setup_acc    = psel && penable && !st_r.pready;
  assign write_acc    = psel && penable && st_r.pready && pwrite && !st_r.pslverr;
  assign div_idx      = paddr[4:2];
  assign div_hit      = (paddr[1:0] == 2'h0) && (paddr <= ADDR_CONVERTER);
  assign core_pending = st_r.staged[DIV_N-1:DIV_CORE_LO] != st_r.applied[DIV_N-1:DIV_CORE_LO];

  always_comb
  begin
    op_mode_t new_mode;
    new_mode = op_mode_t'(pwdata[1:0]);
    st_nxt = st_r;
    st_nxt.pready = 1'b0;
    // answer decode, one wait state into the access phase
    if (setup_acc)
    begin
      st_nxt.pready  = 1'b1;
      st_nxt.pslverr = 1'b0;
      st_nxt.prdata  = 32'h0000_0000;
      if (div_hit)
      begin
        st_nxt.prdata[DIV_W-1:0] = st_r.applied[div_idx];
      end
      else if (paddr == ADDR_MODE)
      begin
        st_nxt.prdata[1:0] = st_r.mode;
        st_nxt.pslverr     = pwrite && (pwdata[1:0] == 2'h3);
      end
      else if (paddr == ADDR_STATUS)
      begin
        st_nxt.prdata[STAT_MODE_LSB +: 2] = st_r.mode;
        st_nxt.prdata[STAT_PEND_BIT]      = core_pending;
        st_nxt.pslverr                    = pwrite;
      end
      else
      begin
        st_nxt.pslverr = 1'b1;
      end
    end
    // writes take effect at the edge that completes the transfer
    if (write_acc)
    begin
      if (div_hit)
      begin
        st_nxt.staged[div_idx] = pwdata[DIV_W-1:0];
        if (div_idx == DIV_IDLE_VCO)
        begin
          st_nxt.applied[DIV_GP_TIMER] = st_r.staged[DIV_GP_TIMER];
          st_nxt.applied[DIV_IDLE_VCO] = pwdata[DIV_W-1:0];
        end
      end
      else if (paddr == ADDR_MODE)
      begin
        st_nxt.mode = new_mode;
        if ((new_mode != st_r.mode) && (new_mode != MODE_IDLE))
        begin
          st_nxt.applied[DIV_N-1:DIV_CORE_LO] = st_r.staged[DIV_N-1:DIV_CORE_LO];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r.staged  <= DIV_RESET;
      st_r.applied <= DIV_RESET;
      st_r.mode    <= MODE_IDLE;
      st_r.pready  <= 1'b0;
      st_r.pslverr <= 1'b0;
      st_r.prdata  <= 32'h0000_0000;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign prdata      = st_r.prdata;
  assign pready      = st_r.pready;
  assign pslverr     = st_r.pslverr;
  assign div_applied = st_r.applied;
  assign op_mode     = st_r.mode;

  // checks
  logic booted_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      booted_r <= 1'b0;
    end
    else
    begin
      booted_r <= 1'b1;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_reset_defaults: assert property (
    !booted_r |-> (div_applied == DIV_RESET) && (op_mode == MODE_IDLE))
    else $error("dividers not at default values after reset");

  chk_hold_applied: assert property (
    !write_acc |=> $stable(div_applied))
    else $error("applied divider changed without a write");

  chk_idle_pair_apply: assert property (
    (write_acc && div_hit && (div_idx == DIV_IDLE_VCO)) |=>
      (div_applied[DIV_IDLE_VCO] == $past(pwdata[DIV_W-1:0])) &&
      (div_applied[DIV_GP_TIMER] == $past(st_r.staged[DIV_GP_TIMER])))
    else $error("idle divider pair not applied on idle write");

  chk_timer_deferred: assert property (
    (write_acc && div_hit && (div_idx == DIV_GP_TIMER)) |=> $stable(div_applied))
    else $error("timer divider applied before idle write");

  chk_core_deferred: assert property (
    (write_acc && div_hit && (div_idx >= DIV_REF)) |=> $stable(div_applied))
    else $error("core divider applied at write time");

  chk_core_on_mode: assert property (
    (write_acc && (paddr == ADDR_MODE) && (pwdata[1:0] != op_mode) &&
     (pwdata[1:0] != MODE_IDLE)) |=>
      (div_applied[DIV_N-1:DIV_CORE_LO] == $past(st_r.staged[DIV_N-1:DIV_CORE_LO])) &&
      (op_mode == $past(pwdata[1:0])))
    else $error("core dividers not applied on entry to rx or tx");

  chk_idle_no_apply: assert property (
    (write_acc && (paddr == ADDR_MODE) && (pwdata[1:0] == MODE_IDLE)) |=>
      $stable(div_applied) ##1 $stable(div_applied) or !$past(write_acc))
    else $error("core dividers applied on return to idle");

  chk_apb_answer: assert property (
    (psel && penable && !pready) |=> pready ##1 !pready)
    else $error("apb answer not a single cycle after one wait state");

  chk_setup_no_answer: assert property (
    (psel && !penable) |=> !pready)
    else $error("answer given in the setup cycle");

  chk_no_request_quiet: assert property (
    !(psel && penable) |=> !pready)
    else $error("answer given without a transfer");

  chk_pready_single: assert property (
    pready |=> !pready)
    else $error("pready held for more than one cycle");

  chk_reset_bus: assert property (
    !booted_r |-> !pready && !pslverr && (prdata == 32'h0000_0000))
    else $error("bus outputs not idle after reset");

  chk_answer_hold: assert property (
    !(psel && penable && !pready) |=> $stable(prdata) && $stable(pslverr))
    else $error("read data or error changed outside an answer");

  chk_mapped_ok: assert property (
    (psel && penable && !pready && !pwrite && (paddr[1:0] == 2'h0) && (paddr <= ADDR_STATUS)) |=>
      pready && !pslverr)
    else $error("read of a mapped register refused");

  chk_unmapped_err: assert property (
    (psel && penable && !pready && ((paddr[1:0] != 2'h0) || (paddr > ADDR_STATUS))) |=>
      pready && pslverr)
    else $error("unmapped address not refused");

  chk_status_write_err: assert property (
    (psel && penable && !pready && pwrite && (paddr == ADDR_STATUS)) |=> pslverr)
    else $error("write to status register not refused");

  chk_mode_code_err: assert property (
    (psel && penable && !pready && pwrite && (paddr == ADDR_MODE) && (pwdata[1:0] == 2'h3)) |=> pslverr)
    else $error("unused mode code not refused");

  chk_read_divider: assert property (
    (psel && penable && !pready && !pwrite && div_hit) |=>
      (prdata[DIV_W-1:0] == $past(st_r.applied[div_idx])) && ((prdata >> DIV_W) == 32'h0000_0000))
    else $error("divider read does not return the applied value");

  chk_read_mode: assert property (
    (psel && penable && !pready && !pwrite && (paddr == ADDR_MODE)) |=>
      (prdata[1:0] == $past(op_mode)) && ((prdata >> 2) == 32'h0000_0000))
    else $error("mode read does not return the mode");

  chk_read_status: assert property (
    (psel && penable && !pready && !pwrite && (paddr == ADDR_STATUS)) |=>
      (prdata[STAT_MODE_LSB +: 2] == $past(op_mode)) && (prdata[STAT_PEND_BIT] == $past(core_pending)) &&
      ((prdata >> (STAT_PEND_BIT + 1)) == 32'h0000_0000))
    else $error("status read does not match mode and pending state");

  chk_mode_load: assert property (
    (write_acc && (paddr == ADDR_MODE)) |=> (op_mode == $past(pwdata[1:0])))
    else $error("mode not taken from the write");

  chk_mode_hold: assert property (
    !(write_acc && (paddr == ADDR_MODE)) |=> $stable(op_mode))
    else $error("mode changed without a mode write");

  chk_mode_legal: assert property (
    (op_mode == MODE_IDLE) || (op_mode == MODE_RX) || (op_mode == MODE_TX))
    else $error("mode holds an unused code");

  chk_same_mode_keep: assert property (
    (write_acc && (paddr == ADDR_MODE) && (pwdata[1:0] == op_mode)) |=> $stable(div_applied))
    else $error("dividers applied on a write of the current mode");

  chk_pending_set: assert property (
    (write_acc && div_hit && (div_idx >= DIV_REF) && (pwdata[DIV_W-1:0] != st_r.applied[div_idx])) |=> core_pending)
    else $error("changed core divider not reported as pending");

  chk_pending_cleared: assert property (
    (write_acc && (paddr == ADDR_MODE) && (pwdata[1:0] != op_mode) && (pwdata[1:0] != MODE_IDLE)) |=>
      !core_pending)
    else $error("core dividers still pending after entry to rx or tx");

  chk_idle_core_keep: assert property (
    (write_acc && div_hit && (div_idx == DIV_IDLE_VCO)) |=> $stable(div_applied[DIV_N-1:DIV_CORE_LO]))
    else $error("core dividers applied on idle divider write");

  chk_refused_no_effect: assert property (
    (psel && penable && pready && pslverr) |=> $stable(st_r.staged) && $stable(div_applied) && $stable(op_mode))
    else $error("refused transfer changed a setting");

  chk_read_no_effect: assert property (
    (psel && penable && pready && !pwrite) |=> $stable(st_r.staged) && $stable(div_applied) && $stable(op_mode))
    else $error("read changed a setting");

  // per divider slot
  for (genvar g = 0; g < DIV_N; g++)
  begin : per_div
    chk_staged_load: assert property (@(posedge pclk) disable iff (!presetn)
      (write_acc && div_hit && (div_idx == 3'(g))) |=> (st_r.staged[g] == $past(pwdata[DIV_W-1:0])))
      else $error("divider not staged from the low bits of the write");

    chk_staged_keep: assert property (@(posedge pclk) disable iff (!presetn)
      !(write_acc && div_hit && (div_idx == 3'(g))) |=> $stable(st_r.staged[g]))
      else $error("staged divider changed without a write to it");

    if (g == DIV_IDLE_VCO)
    begin : idle_slot
      chk_applied_source: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(div_applied[g]) |-> (div_applied[g] == st_r.staged[g]))
        else $error("idle divider applied from a value other than the write");
    end
    else
    begin : other_slot
      chk_applied_source: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(div_applied[g]) |-> (div_applied[g] == $past(st_r.staged[g])))
        else $error("divider applied from a value other than its staged one");
    end
  end

  cov_idle_apply: cover property (write_acc && div_hit && (div_idx == DIV_IDLE_VCO));
  cov_rx_entry:   cover property (write_acc && (paddr == ADDR_MODE) && (pwdata[1:0] == MODE_RX) && core_pending);
  cov_tx_entry:   cover property (write_acc && (paddr == ADDR_MODE) && (pwdata[1:0] == MODE_TX));
  cov_bus_error:  cover property (pready && pslverr);
  cov_idle_return: cover property (write_acc && (paddr == ADDR_MODE) && (pwdata[1:0] == MODE_IDLE));

endmodule : refclk_div_cfg

// ==== testbench/host_apb.sv ====
// partner model: host controller acting as apb master
`timescale 1ns/1ps
module host_apb
(
  // clock
  input  wire logic        pclk,
  // apb master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // one transfer; an idle cycle comes first so signals never change twice in one step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    if (n >= 20)
    begin
      tb.bad_count++;
      tb.wrap_up();
    end
  endtask : xfer
endmodule : host_apb

// ==== testbench/tb.sv ====
// testbench: divider configuration block driven over apb
`timescale 1ns/1ps
module tb;
  import refclk_div_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  div_array_t  div_applied;
  op_mode_t    op_mode;
  int          bad_count, checks;

  refclk_div_cfg dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .div_applied(div_applied), .op_mode(op_mode));
  host_apb host_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task chk(input string n, input logic [63:0] x, input logic [63:0] g);
    checks++;
    if (g !== x)
    begin
      $display("unexpected %s expected %h seen %h", n, x, g);
      bad_count++;
    end
  endtask : chk
  task rdc(input logic [7:0] a, input logic [31:0] x);
    host_u.xfer(1'b0, a, 32'h0, q, e);
    chk("prdata", x, q);
    chk("pslverr", 0, e);
  endtask : rdc
  task wr(input logic [7:0] a, input logic [31:0] d, input logic xe);
    host_u.xfer(1'b1, a, d, q, e);
    chk("pslverr", xe, e);
  endtask : wr
  task defaults;
    chk("div_applied", DIV_RESET, div_applied);
    chk("op_mode", MODE_IDLE, op_mode);
    for (int i = 0; i < DIV_N; i++)
      rdc(8'(4 * i), 32'(DIV_RESET[i]));
  endtask : defaults
  task wrap_up;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up

  initial
  begin
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    defaults();
    wr(ADDR_GP_TIMER, 32'hFFFFF019, 1'b0);
    rdc(ADDR_GP_TIMER, 32'h018);
    wr(ADDR_IDLE_VCO, 32'hFFFFF10F, 1'b0);
    rdc(ADDR_GP_TIMER, 32'h019);
    rdc(ADDR_IDLE_VCO, 32'h10F);
    wr(ADDR_REF, 32'h07D, 1'b0);
    wr(ADDR_PLL, 32'h300, 1'b0);
    wr(ADDR_ACTIVE_VCO, 32'h0C0, 1'b0);
    wr(ADDR_CONVERTER, 32'hC00F, 1'b0);
    rdc(ADDR_REF, 32'h040);
    rdc(ADDR_STATUS, 32'h4);
    wr(ADDR_MODE, 32'h1, 1'b0);
    @(posedge pclk);
    chk("div_applied", {10'h00F, 10'h0C0, 10'h300, 10'h07D, 10'h10F, 10'h019}, div_applied);
    chk("op_mode", MODE_RX, op_mode);
    wr(ADDR_REF, 32'h155, 1'b0);
    wr(ADDR_MODE, 32'h1, 1'b0);
    rdc(ADDR_REF, 32'h07D);
    wr(ADDR_MODE, 32'h2, 1'b0);
    rdc(ADDR_REF, 32'h155);
    rdc(ADDR_MODE, 32'h2);
    wr(ADDR_REF, 32'h0C8, 1'b0);
    wr(ADDR_MODE, 32'h0, 1'b0);
    rdc(ADDR_REF, 32'h155);
    rdc(ADDR_STATUS, 32'h4);
    wr(ADDR_MODE, 32'h3, 1'b1);
    rdc(ADDR_MODE, 32'h0);
    wr(ADDR_STATUS, 32'h0, 1'b1);
    host_u.xfer(1'b0, 8'h20, 32'h0, q, e);
    chk("pslverr", 1, e);
    host_u.xfer(1'b0, 8'h02, 32'h0, q, e);
    chk("pslverr", 1, e);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    defaults();
    wrap_up();
  end
endmodule : tb
